//--- rtl/port_pin_function_mux.sv
// Port pins, alternate pin functions and external interrupt edges.
// Assumes a classic Wishbone master and pin levels synchronous to CLK_I.
//
// Operation
// RQ1: Port 0 has four per-bit direction pins.
// RQ2: Pull-up bit connects a pin pull-up.
// RQ3: Port 2 bits switch to analog inputs.
// RQ4: Port 3: four I/O plus reset-shared input.
// RQ5: Port 3 low pins carry timer, interrupts.
// RQ6: Interrupt edges: rising, falling or both.
// RQ7: First timer pin: count clock or capture.
// RQ8: Second timer pin captures first register only.
// RQ9: Port 4 eight pins, four with alternates.
// RQ10: Serial pins; transmit pin input after reset.
// RQ11: Port 12 direction; pull-up first, last only.
// RQ12: Port 12 middle pins may be oscillator.
// RQ13: Oscillator pins pulled low during reset.
// RQ14: Port 13 is one output-only pin.
// RQ15: Pin reset is active low.
// RQ16: Output drives latch; input reads pin.
`timescale 1ns/1ps
`include "port_mux_cfg.svh"
module port_pin_function_mux (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic [`PM_ADR_W-1:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic IRQ_O,
  // Configuration byte straps
  input wire logic OPT_PIN_RESET_I,
  input wire logic OPT_OSC_PINS_I,
  // Port 0
  input wire logic [3:0] P0_I,
  output logic [3:0] P0_O,
  output logic [3:0] P0_OE_N_O,
  output logic [3:0] P0_PU_O,
  // Port 2 and analog inputs
  input wire logic [3:0] P2_I,
  output logic [3:0] P2_O,
  output logic [3:0] P2_OE_N_O,
  output logic [3:0] P2_PU_O,
  output logic [3:0] ANALOG_SEL_O,
  // Port 3 and the input-only reset-shared pin
  input wire logic [3:0] P3_I,
  output logic [3:0] P3_O,
  output logic [3:0] P3_OE_N_O,
  output logic [3:0] P3_PU_O,
  input wire logic P34_I,
  output logic PIN_RESET_REQ_O,
  // Port 4
  input wire logic [7:0] P4_I,
  output logic [7:0] P4_O,
  output logic [7:0] P4_OE_N_O,
  output logic [7:0] P4_PU_O,
  // Port 12 and oscillator pins
  input wire logic [3:0] P12_I,
  output logic [3:0] P12_O,
  output logic [3:0] P12_OE_N_O,
  output logic [3:0] P12_PU_O,
  output logic [3:0] P12_PD_O,
  output logic OSC_SEL_O,
  // Port 13
  output logic P13_O,
  // Peripheral side
  input wire logic TIMER16_OUT_I,
  input wire logic TIMER8_OUT_I,
  input wire logic SERIAL_TX_I,
  output logic SERIAL_RX_O,
  output logic TIMER_COUNT_CLK_O,
  output logic CAPTURE_BOTH_O,
  output logic CAPTURE_FIRST_O
);

  localparam logic [47:0] WMASK = `PM_WIDTH_MASK;
  localparam logic [47:0] DMASK = `PM_DIR_MASK;
  localparam logic [47:0] PMASK = `PM_PULLUP_MASK;
  localparam logic [47:0] CMASK = `PM_CTRL_MASK;

  port_mux_pkg::port_byte_t latch_q [`PM_NPORT];
  port_mux_pkg::port_byte_t dir_q [`PM_NPORT];
  port_mux_pkg::port_byte_t pu_q [`PM_NPORT];
  port_mux_pkg::port_byte_t ctl_q [`PM_NPORT];
  port_mux_pkg::port_byte_t pin_in [`PM_NPORT];
  logic [7:0] edge_sel_q;
  logic timer_count_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  logic opt_rst_q;
  logic opt_osc_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic wr_en;
  logic [3:0] irq_evt;
  pin_evt_if evt_if ();

  function automatic logic [7:0] field(input logic [47:0] m, input int k);
    field = m[8*k +: 8];
  endfunction

  // Input bits show the pin, output bits show the latch.
  function automatic logic [7:0] rd_port(input logic [7:0] l, input logic [7:0] d,
                                         input logic [7:0] p);
    rd_port = (d & p) | (~d & l);
  endfunction

  assign pin_in[`PM_P0] = {4'h0, P0_I};
  assign pin_in[`PM_P2] = {4'h0, P2_I};
  assign pin_in[`PM_P3] = {3'h0, P34_I, P3_I};
  assign pin_in[`PM_P4] = P4_I;
  assign pin_in[`PM_P12] = {4'h0, P12_I};
  assign pin_in[`PM_P13] = 8'h00;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // One wait state: ack follows the request by a cycle and drops after one.
  assign wr_en = CYC_I & STB_I & WE_I & ack_q & SEL_I[0];
  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= CYC_I & STB_I & ~ack_q;
    end
  end

  always_comb begin
    int k;
    k = int'(ADR_I[6:4]);
    rd_d = 32'h0000_0000;
    if (ADR_I[7] == 1'b0 && ADR_I[1:0] == 2'h0 && k < `PM_NPORT) begin
      unique case (ADR_I[3:2])
        `PM_F_LATCH: rd_d[7:0] = rd_port(latch_q[k], dir_q[k], pin_in[k]) & field(WMASK, k); // RQ16
        `PM_F_DIR: rd_d[7:0] = dir_q[k] & field(DMASK, k);
        `PM_F_PULLUP: rd_d[7:0] = pu_q[k] & field(PMASK, k);
        `PM_F_CTRL: rd_d[7:0] = ctl_q[k] & field(CMASK, k);
      endcase
    end else begin
      unique case (ADR_I)
        `PM_OFS_EDGE_SEL: rd_d[7:0] = edge_sel_q;
        `PM_OFS_TIMER_MODE: rd_d[0] = timer_count_q;
        `PM_OFS_IRQ_STATUS: rd_d[3:0] = irq_stat_q;
        `PM_OFS_IRQ_ENABLE: rd_d[3:0] = irq_en_q;
        `PM_OFS_OPTION: rd_d[1:0] = {opt_osc_q, opt_rst_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      dat_q <= 32'h0000_0000;
    end else if (CYC_I & STB_I & ~WE_I & ~ack_q) begin
      dat_q <= rd_d;
    end
  end

  // ----------------------------------------
  // Port registers
  // ----------------------------------------
  // Directions reset to input, which leaves the transmit pin undriven.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      for (int k = 0; k < `PM_NPORT; k++) begin
        latch_q[k] <= 8'h00;
        dir_q[k] <= `PM_DIR_RESET; // RQ10
        pu_q[k] <= 8'h00;
        ctl_q[k] <= 8'h00;
      end
    end else if (wr_en && ADR_I[7] == 1'b0) begin
      for (int k = 0; k < `PM_NPORT; k++) begin
        if (int'(ADR_I[6:4]) == k) begin
          unique case (ADR_I[3:2])
            `PM_F_LATCH: latch_q[k] <= DAT_I[7:0] & field(WMASK, k);
            `PM_F_DIR: dir_q[k] <= (DAT_I[7:0] & field(DMASK, k)) | ~field(DMASK, k); // RQ1 RQ14
            `PM_F_PULLUP: pu_q[k] <= DAT_I[7:0] & field(PMASK, k); // RQ11
            `PM_F_CTRL: ctl_q[k] <= DAT_I[7:0] & field(CMASK, k);
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      edge_sel_q <= 8'h00;
      timer_count_q <= 1'b0;
      irq_en_q <= 4'h0;
    end else if (wr_en) begin
      if (ADR_I == `PM_OFS_EDGE_SEL) begin
        edge_sel_q <= DAT_I[7:0];
      end
      if (ADR_I == `PM_OFS_TIMER_MODE) begin
        timer_count_q <= DAT_I[0];
      end
      if (ADR_I == `PM_OFS_IRQ_ENABLE) begin
        irq_en_q <= DAT_I[3:0];
      end
    end
  end

  // Straps are caught while reset is held, never through the reset itself.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      opt_rst_q <= OPT_PIN_RESET_I; // RQ4
      opt_osc_q <= OPT_OSC_PINS_I; // RQ12
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Output enables are active low; a set direction bit means input.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      P0_O <= 4'h0;
      P0_OE_N_O <= 4'hF;
      P0_PU_O <= 4'h0;
      P2_O <= 4'h0;
      P2_OE_N_O <= 4'hF;
      P2_PU_O <= 4'h0;
      ANALOG_SEL_O <= 4'h0;
      P3_O <= 4'h0;
      P3_OE_N_O <= 4'hF;
      P3_PU_O <= 4'h0;
      P4_O <= 8'h00;
      P4_OE_N_O <= 8'hFF;
      P4_PU_O <= 8'h00;
      P12_O <= 4'h0;
      P12_OE_N_O <= 4'hF;
      P12_PU_O <= 4'h0;
      P12_PD_O <= `PM_OSC_BITS; // RQ13
      P13_O <= 1'b0;
    end else begin
      P0_O <= latch_q[`PM_P0][3:0]; // RQ16
      P0_OE_N_O <= dir_q[`PM_P0][3:0]; // RQ1
      P0_PU_O <= pu_q[`PM_P0][3:0] & dir_q[`PM_P0][3:0]; // RQ2
      // An analog channel never has its digital driver or pull-up on.
      P2_O <= latch_q[`PM_P2][3:0];
      P2_OE_N_O <= dir_q[`PM_P2][3:0] | ctl_q[`PM_P2][3:0]; // RQ3
      P2_PU_O <= pu_q[`PM_P2][3:0] & dir_q[`PM_P2][3:0] & ~ctl_q[`PM_P2][3:0];
      ANALOG_SEL_O <= ctl_q[`PM_P2][3:0]; // RQ3
      P3_O <= {latch_q[`PM_P3][3:2],
               ctl_q[`PM_P3][1] ? TIMER16_OUT_I : latch_q[`PM_P3][1], // RQ5
               latch_q[`PM_P3][0]};
      P3_OE_N_O <= dir_q[`PM_P3][3:0]; // RQ4
      P3_PU_O <= pu_q[`PM_P3][3:0] & dir_q[`PM_P3][3:0]; // RQ2
      P4_O <= {latch_q[`PM_P4][7:4],
               ctl_q[`PM_P4][3] ? SERIAL_TX_I : latch_q[`PM_P4][3], // RQ10
               ctl_q[`PM_P4][2] ? TIMER8_OUT_I : latch_q[`PM_P4][2], // RQ9
               latch_q[`PM_P4][1:0]};
      P4_OE_N_O <= dir_q[`PM_P4]; // RQ9
      P4_PU_O <= pu_q[`PM_P4] & dir_q[`PM_P4]; // RQ2
      // Oscillator pins are left entirely to the oscillator.
      P12_O <= latch_q[`PM_P12][3:0] & ~({4{opt_osc_q}} & `PM_OSC_BITS);
      P12_OE_N_O <= dir_q[`PM_P12][3:0] | ({4{opt_osc_q}} & `PM_OSC_BITS); // RQ12
      P12_PU_O <= pu_q[`PM_P12][3:0] & dir_q[`PM_P12][3:0]; // RQ11
      P12_PD_O <= 4'h0;
      P13_O <= latch_q[`PM_P13][0]; // RQ14
    end
  end

  assign OSC_SEL_O = opt_osc_q; // RQ12
  assign PIN_RESET_REQ_O = opt_rst_q & ~P34_I; // RQ15

  // ----------------------------------------
  // Input functions and edges
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      SERIAL_RX_O <= 1'b1;
    end else begin
      SERIAL_RX_O <= ctl_q[`PM_P4][4] ? P4_I[4] : 1'b1; // RQ10
    end
  end

  // Lanes 0-3: interrupt inputs a-d; 4: timer clock/capture; 5: capture.
  assign evt_if.lvl = {P3_I[1], P3_I[0], P4_I[1], P3_I[1], P4_I[3], P3_I[0]};
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      evt_if.mode[i] = port_mux_pkg::edge_sel_e'(edge_sel_q[2*i +: 2]); // RQ6
    end
    evt_if.mode[4] = ctl_q[`PM_P3][0] ? port_mux_pkg::EDGE_RISE : port_mux_pkg::EDGE_OFF;
    evt_if.mode[5] = ctl_q[`PM_P3][1] ? port_mux_pkg::EDGE_RISE : port_mux_pkg::EDGE_OFF;
  end

  pin_edge_detect u_edges (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .evt_if(evt_if)
  );

  assign irq_evt = evt_if.evt[3:0] &
                   {ctl_q[`PM_P4][1], ctl_q[`PM_P3][1], ctl_q[`PM_P4][3], ctl_q[`PM_P3][0]}; // RQ5

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      TIMER_COUNT_CLK_O <= 1'b0;
      CAPTURE_BOTH_O <= 1'b0;
      CAPTURE_FIRST_O <= 1'b0;
    end else begin
      TIMER_COUNT_CLK_O <= evt_if.evt[4] & timer_count_q; // RQ7
      CAPTURE_BOTH_O <= evt_if.evt[4] & ~timer_count_q; // RQ7
      CAPTURE_FIRST_O <= evt_if.evt[5]; // RQ8
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // A new edge wins over a clear written in the same cycle.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_en && ADR_I == `PM_OFS_IRQ_CLEAR) ? DAT_I[3:0] : 4'h0))
                    | irq_evt; // RQ6
    end
  end

  assign IRQ_O = |(irq_stat_q & irq_en_q);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  property p_p0_dir;
    wr_en && ADR_I == 8'h04 |-> ##2 P0_OE_N_O == $past(DAT_I[3:0], 2);
  endproperty
  a_p0_dir: assert property (p_p0_dir) else $error("port 0 direction not applied"); // RQ1

  property p_pullup;
    (P4_PU_O & ~P4_OE_N_O) == 8'h00;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on a driven pin"); // RQ2

  property p_analog;
    (ANALOG_SEL_O & ~P2_OE_N_O) == 4'h0 && (ANALOG_SEL_O & P2_PU_O) == 4'h0;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin driven"); // RQ3

  property p_irq_a;
    edge_sel_q[1:0] == 2'h1 && ctl_q[`PM_P3][0] && $rose(P3_I[0]) && irq_en_q[0]
      |=> IRQ_O && irq_stat_q[0];
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("rising edge missed"); // RQ6

  property p_capture_first;
    ctl_q[`PM_P3][1] && $rose(P3_I[1]) |=> CAPTURE_FIRST_O ##1 !CAPTURE_FIRST_O;
  endproperty
  a_capture_first: assert property (p_capture_first) else $error("capture pulse wrong"); // RQ8

  property p_count_excl;
    !(TIMER_COUNT_CLK_O && CAPTURE_BOTH_O);
  endproperty
  a_count_excl: assert property (p_count_excl) else $error("timer pin in two roles"); // RQ7

  property p_timer8;
    ctl_q[`PM_P4][2] ##1 ctl_q[`PM_P4][2] |-> P4_O[2] == $past(TIMER8_OUT_I);
  endproperty
  a_timer8: assert property (p_timer8) else $error("timer output not routed"); // RQ9

  property p_tx_reset;
    $fell(RESET_I) |-> P4_OE_N_O[3];
  endproperty
  a_tx_reset: assert property (disable iff (1'b0) p_tx_reset) else $error("tx driven"); // RQ10

  property p_osc_pd;
    RESET_I |=> P12_PD_O == `PM_OSC_BITS && (P12_OE_N_O & `PM_OSC_BITS) == `PM_OSC_BITS;
  endproperty
  a_osc_pd: assert property (disable iff (1'b0) p_osc_pd) else $error("no pull-down"); // RQ13

  property p_p12_pu;
    (P12_PU_O & `PM_OSC_BITS) == 4'h0;
  endproperty
  a_p12_pu: assert property (p_p12_pu) else $error("pull-up on middle pin"); // RQ11

  property p_pin_reset;
    opt_rst_q && !P34_I |-> PIN_RESET_REQ_O;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored"); // RQ15

endmodule

//--- include/port_mux_cfg.svh
// Offsets, field masks, reset values and timing counts of the port block.
// Assumes a Wishbone byte address of 8 bits with one 32-bit word per register.
`ifndef PORT_MUX_CFG_SVH
`define PORT_MUX_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PM_ADR_W 8
`define PM_NPORT 6
`define PM_F_LATCH 2'h0
`define PM_F_DIR 2'h1
`define PM_F_PULLUP 2'h2
`define PM_F_CTRL 2'h3
`define PM_OFS_EDGE_SEL 8'h60
`define PM_OFS_TIMER_MODE 8'h64
`define PM_OFS_IRQ_STATUS 8'h68
`define PM_OFS_IRQ_CLEAR 8'h6C
`define PM_OFS_IRQ_ENABLE 8'h70
`define PM_OFS_OPTION 8'h74

// ----------------------------------------
// Port indices and bit masks
// ----------------------------------------
`define PM_P0 0
`define PM_P2 1
`define PM_P3 2
`define PM_P4 3
`define PM_P12 4
`define PM_P13 5
`define PM_WIDTH_MASK {8'h01, 8'h0F, 8'hFF, 8'h1F, 8'h0F, 8'h0F}
`define PM_DIR_MASK {8'h00, 8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'h0F}
`define PM_PULLUP_MASK {8'h00, 8'h09, 8'hFF, 8'h0F, 8'h0F, 8'h0F}
`define PM_CTRL_MASK {8'h00, 8'h00, 8'h1E, 8'h03, 8'h0F, 8'h00}
`define PM_DIR_RESET 8'hFF
`define PM_OSC_BITS 4'h6

// ----------------------------------------
// Timing
// ----------------------------------------
`define PM_CLK_PERIOD_NS 10
`define PM_EVT_LATENCY 2

`endif

//--- include/port_mux_pkg.sv
// Types shared by the port block and its edge detector.
// Assumes port_mux_cfg.svh for all numeric constants.
package port_mux_pkg;

  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_e;
  typedef logic [7:0] port_byte_t;

endpackage

//--- include/pin_evt_if.sv
// Carrier between the port block and its edge detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pin_evt_if;
  logic [5:0] lvl;
  port_mux_pkg::edge_sel_e mode [6];
  logic [5:0] evt;
  modport det (input lvl, input mode, output evt);
  modport user (output lvl, output mode, input evt);
endinterface

//--- rtl/pin_edge_detect.sv
// Edge detector for six sampled pin levels, each with its own edge choice.
// Assumes levels are already synchronous to CLK_I.
`timescale 1ns/1ps
`include "port_mux_cfg.svh"
module pin_edge_detect (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels and events
  pin_evt_if.det evt_if
);

  logic [5:0] prev_q;
  logic armed_q;

  // ----------------------------------------
  // History
  // ----------------------------------------
  // The first sample after reset only loads history, so a pin that is
  // already high is not mistaken for a rising edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 6'h00;
      armed_q <= 1'b0;
    end else begin
      prev_q <= evt_if.lvl;
      armed_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Edge selection
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      unique case (evt_if.mode[i])
        port_mux_pkg::EDGE_OFF: evt_if.evt[i] = 1'b0;
        port_mux_pkg::EDGE_RISE: evt_if.evt[i] = armed_q & evt_if.lvl[i] & ~prev_q[i];
        port_mux_pkg::EDGE_FALL: evt_if.evt[i] = armed_q & ~evt_if.lvl[i] & prev_q[i];
        port_mux_pkg::EDGE_BOTH: evt_if.evt[i] = armed_q & (evt_if.lvl[i] ^ prev_q[i]);
      endcase
    end
  end

endmodule

//--- dv/pin_world.sv
// Model of the board circuitry that stands on one group of port pins.
// Assumes active-low output enables and active-high pull-up enables from the block.
`timescale 1ns/1ps
module pin_world #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic [W-1:0] ext_v_i,
  input wire logic [W-1:0] ext_en_i,
  input wire logic [W-1:0] drv_i,
  input wire logic [W-1:0] oe_n_i,
  input wire logic [W-1:0] pu_i,
  output logic [W-1:0] pin_o
);
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // A floating pin toggles every cycle so that no stale level can pass for data.
  logic tog_q = 1'b0;
  always_ff @(posedge clk_i) begin
    tog_q <= ~tog_q;
  end
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (!oe_n_i[b]) begin
        pin_o[b] = drv_i[b];
      end else if (ext_en_i[b]) begin
        pin_o[b] = ext_v_i[b];
      end else if (pu_i[b]) begin
        pin_o[b] = 1'b1;
      end else begin
        pin_o[b] = tog_q;
      end
    end
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the port and pin-function block.
// Assumes pin_world models stand on every bidirectional port.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] dat_o, rd;
  logic ack, irq, rst_req, osc_sel, rx, cnt_clk, cap_both, cap_first, p13;
  logic opt_rst = 1'b1;
  logic opt_osc = 1'b1;
  logic p34 = 1'b0;
  logic t16 = 1'b0;
  logic t8 = 1'b0;
  logic tx = 1'b1;
  logic [3:0] sel = 4'hF;
  logic [7:0] ext_en = 8'hFF;
  logic [3:0] p0_x = 4'h3, p2_x = 4'h0, p3_x = 4'h0, p12_x = 4'h0;
  logic [7:0] p4_x = 8'hFF;
  logic [3:0] p0_i, p0_o, p0_oe, p0_pu, p2_i, p2_o, p2_oe, p2_pu, an;
  logic [3:0] p3_i, p3_o, p3_oe, p3_pu, p12_i, p12_o, p12_oe, p12_pu, p12_pd;
  logic [7:0] p4_i, p4_o, p4_oe, p4_pu;
  int err_count = 0;
  int check_count = 0;
  int n_clk = 0;
  int n_cb = 0;
  int n_cf = 0;

  always #5 clk = ~clk;
  always @(posedge clk) begin
    n_clk <= n_clk + int'(cnt_clk === 1'b1);
    n_cb <= n_cb + int'(cap_both === 1'b1);
    n_cf <= n_cf + int'(cap_first === 1'b1);
  end

  pin_world #(.W(4)) i_w0 (.clk_i(clk), .ext_v_i(p0_x), .ext_en_i(ext_en[3:0]), .drv_i(p0_o),
    .oe_n_i(p0_oe), .pu_i(p0_pu), .pin_o(p0_i));
  pin_world #(.W(4)) i_w2 (.clk_i(clk), .ext_v_i(p2_x), .ext_en_i(ext_en[3:0]), .drv_i(p2_o),
    .oe_n_i(p2_oe), .pu_i(p2_pu), .pin_o(p2_i));
  pin_world #(.W(4)) i_w3 (.clk_i(clk), .ext_v_i(p3_x), .ext_en_i(ext_en[3:0]), .drv_i(p3_o),
    .oe_n_i(p3_oe), .pu_i(p3_pu), .pin_o(p3_i));
  pin_world #(.W(8)) i_w4 (.clk_i(clk), .ext_v_i(p4_x), .ext_en_i(ext_en), .drv_i(p4_o),
    .oe_n_i(p4_oe), .pu_i(p4_pu), .pin_o(p4_i));
  pin_world #(.W(4)) i_w12 (.clk_i(clk), .ext_v_i(p12_x), .ext_en_i(ext_en[3:0]), .drv_i(p12_o),
    .oe_n_i(p12_oe), .pu_i(p12_pu), .pin_o(p12_i));

  port_pin_function_mux i_port_pin_function_mux (
    .CLK_I(clk), .RESET_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .SEL_I(sel),
    .ADR_I(adr), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .IRQ_O(irq),
    .OPT_PIN_RESET_I(opt_rst), .OPT_OSC_PINS_I(opt_osc),
    .P0_I(p0_i), .P0_O(p0_o), .P0_OE_N_O(p0_oe), .P0_PU_O(p0_pu),
    .P2_I(p2_i), .P2_O(p2_o), .P2_OE_N_O(p2_oe), .P2_PU_O(p2_pu), .ANALOG_SEL_O(an),
    .P3_I(p3_i), .P3_O(p3_o), .P3_OE_N_O(p3_oe), .P3_PU_O(p3_pu), .P34_I(p34),
    .PIN_RESET_REQ_O(rst_req), .P4_I(p4_i), .P4_O(p4_o), .P4_OE_N_O(p4_oe), .P4_PU_O(p4_pu),
    .P12_I(p12_i), .P12_O(p12_o), .P12_OE_N_O(p12_oe), .P12_PU_O(p12_pu), .P12_PD_O(p12_pd),
    .OSC_SEL_O(osc_sel), .P13_O(p13), .TIMER16_OUT_I(t16), .TIMER8_OUT_I(t8),
    .SERIAL_TX_I(tx), .SERIAL_RX_O(rx), .TIMER_COUNT_CLK_O(cnt_clk),
    .CAPTURE_BOTH_O(cap_both), .CAPTURE_FIRST_O(cap_first));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Entered just after a rising edge; returns one idle cycle after the ack edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_after_reset;
    chk("pull_down_off", {28'h0, p12_pd}, 32'h0);
    chk("p4_oe_n", {24'h0, p4_oe}, 32'hFF);
    wb(1'b0, 8'h04, 32'h0);
    chk("p0_dir", rd, 32'h0F);
    wb(1'b0, 8'h44, 32'h0);
    chk("p12_dir", rd, 32'h0F);
    $display("test after_reset done");
  endtask

  task automatic t_port0;
    wb(1'b1, 8'h04, 32'h05);
    wb(1'b1, 8'h00, 32'h0A);
    tick(2);
    chk("p0_oe_n", {28'h0, p0_oe}, 32'h5);
    chk("p0_out", {30'h0, p0_o[3], p0_o[1]}, 32'h3);
    wb(1'b0, 8'h00, 32'h0);
    chk("p0_read", rd, 32'h0B);
    $display("test port0 done");
  endtask

  task automatic t_pullup;
    wb(1'b1, 8'h04, 32'h0F);
    wb(1'b1, 8'h08, 32'h0F);
    wb(1'b1, 8'h48, 32'h0F);
    wb(1'b1, 8'h1C, 32'h05);
    wb(1'b1, 8'h18, 32'h0F);
    tick(2);
    chk("p0_pu", {28'h0, p0_pu}, 32'hF);
    chk("p12_pu", {28'h0, p12_pu}, 32'h9);
    chk("analog", {28'h0, an}, 32'h5);
    chk("p2_pu_digital", {28'h0, p2_pu}, 32'hA);
    wb(1'b0, 8'h48, 32'h0);
    chk("p12_pu_reg", rd, 32'h09);
    ext_en <= 8'hF0;
    wb(1'b0, 8'h00, 32'h0);
    chk("p0_pulled_up", rd, 32'h0F);
    ext_en <= 8'hFF;
    $display("test pullup_analog done");
  endtask

  task automatic t_irq_edges;
    wb(1'b1, 8'h2C, 32'h03);
    wb(1'b1, 8'h70, 32'h0F);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 8'h60, m);
      wb(1'b1, 8'h6C, 32'h0F);
      p3_x <= 4'h1;
      tick(4);
      wb(1'b0, 8'h68, 32'h0);
      chk("rise_seen", {31'h0, rd[0]}, 32'(m == 1 || m == 3));
      chk("irq_level", {31'h0, irq}, 32'(m == 1 || m == 3));
      wb(1'b1, 8'h6C, 32'h0F);
      p3_x <= 4'h0;
      tick(4);
      wb(1'b0, 8'h68, 32'h0);
      chk("fall_seen", {31'h0, rd[0]}, 32'(m >= 2));
    end
    wb(1'b1, 8'h70, 32'h0);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    $display("test irq_edges done");
  endtask

  task automatic t_timer;
    int c0, c1, c2;
    wb(1'b1, 8'h64, 32'h01);
    c0 = n_clk;
    p3_x <= 4'h1;
    tick(4);
    chk("count_clk", n_clk - c0, 32'h1);
    p3_x <= 4'h0;
    wb(1'b1, 8'h64, 32'h00);
    c1 = n_cb;
    c2 = n_cf;
    p3_x <= 4'h1;
    tick(4);
    chk("capture_both", n_cb - c1, 32'h1);
    p3_x <= 4'h3;
    tick(4);
    chk("capture_first", n_cf - c2, 32'h1);
    chk("first_only", n_cb - c1, 32'h1);
    $display("test timer done");
  endtask

  task automatic t_serial;
    wb(1'b1, 8'h3C, 32'h1C);
    wb(1'b1, 8'h34, 32'hF3);
    tx <= 1'b0;
    t8 <= 1'b1;
    p4_x <= 8'hEF;
    tick(3);
    chk("tx_rx_t8", {29'h0, p4_o[3], p4_o[2], rx}, 32'h2);
    tx <= 1'b1;
    t8 <= 1'b0;
    p4_x <= 8'hFF;
    tick(3);
    chk("tx_rx_t8_b", {29'h0, p4_o[3], p4_o[2], rx}, 32'h5);
    $display("test serial done");
  endtask

  task automatic t_misc;
    wb(1'b1, 8'h50, 32'h01);
    tick(2);
    chk("p13_out", {31'h0, p13}, 32'h1);
    wb(1'b0, 8'h54, 32'h0);
    chk("p13_no_dir", rd, 32'h0);
    chk("pin_reset_low", {31'h0, rst_req}, 32'h1);
    p34 <= 1'b1;
    tick(2);
    chk("pin_reset_high", {31'h0, rst_req}, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk("p34_read", {31'h0, rd[4]}, 32'h1);
    chk("osc_sel", {31'h0, osc_sel}, 32'h1);
    wb(1'b0, 8'h74, 32'h0);
    chk("straps", rd, 32'h3);
    wb(1'b1, 8'h24, 32'h0D);
    t16 <= 1'b1;
    tick(2);
    chk("p3_timer16_hi", {30'h0, p3_oe[1], p3_o[1]}, 32'h1);
    t16 <= 1'b0;
    wb(1'b1, 8'h44, 32'h00);
    wb(1'b1, 8'h40, 32'h0F);
    tick(2);
    chk("p3_timer16_lo", {31'h0, p3_o[1]}, 32'h0);
    chk("p12_osc_pins", {24'h0, p12_oe, p12_o}, 32'h69);
    $display("test misc done");
  endtask

  // A second reset in mid-run, with both straps now off.
  task automatic t_reset2;
    opt_rst <= 1'b0;
    opt_osc <= 1'b0;
    p34 <= 1'b0;
    rst <= 1'b1;
    tick(2);
    chk("pull_down_rst2", {28'h0, p12_pd}, 32'h6);
    rst <= 1'b0;
    tick(1);
    sel <= 4'h0;
    wb(1'b1, 8'h50, 32'h01);
    sel <= 4'hF;
    wb(1'b1, 8'h44, 32'h00);
    tick(2);
    chk("pull_down_rel2", {28'h0, p12_pd}, 32'h0);
    chk("sel_ignored", {31'h0, p13}, 32'h0);
    chk("osc_off", {27'h0, osc_sel, p12_oe}, 32'h0);
    chk("pin_reset_off", {31'h0, rst_req}, 32'h0);
    wb(1'b0, 8'h74, 32'h0);
    chk("straps2", rd, 32'h0);
    $display("test reset2 done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    tick(10);
    chk("pull_down_rst", {28'h0, p12_pd}, 32'h6);
    tick(2);
    rst <= 1'b0;
    tick(3);
    t_after_reset();
    t_port0();
    t_pullup();
    t_irq_edges();
    t_timer();
    t_serial();
    t_misc();
    t_reset2();
    finish_test();
  end

  initial begin
    tick(20000);
    err_count++;
    finish_test();
  end
endmodule
